/* src/decoder_host_readout_and_l4_check.sv */
/*
 host readout side: status and block number registers, payload readout
 over parallel bus, dma or serial bus, and the group checker input.
 assumes the decoder core loads packet flags and payload on ref_clk and
 that control register bits arrive as plain same-clock levels.
*/
`timescale 1ns/100ps
`default_nettype none
`include "readout_map.svh"
module decoder_host_readout_and_l4_check
    import readout_pkg::*;
#(
    parameter int UPDATE_CYCLES = `UPDATE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic pkt_load,
    input wire logic pkt_second_pass,
    input wire logic pkt_block_locked,
    input wire logic pkt_frame_locked,
    input wire logic pkt_error,
    input wire logic pkt_parity,
    input wire logic pkt_head,
    input wire logic [7:0] pkt_number,
    input wire logic pay_we,
    input wire logic [5:0] pay_addr,
    input wire logic [7:0] pay_wdata,
    input wire logic second_pass_halt,
    input wire logic group_check_clear,
    input wire logic dma_enable,
    input wire logic dma_read_sel,
    input wire logic request_active_high,
    input wire logic acknowledge_active_high,
    input wire logic bus_select_pin,
    input wire logic chip_select_b,
    input wire logic read_b,
    input wire logic write_b,
    input wire logic [3:0] bus_addr,
    input wire logic bus_word,
    input wire logic [7:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    output logic transfer_request,
    input wire logic transfer_acknowledge,
    input wire logic serial_clock_in,
    input wire logic chip_enable,
    input wire logic serial_data_in,
    output logic serial_out,
    output logic serial_out_oe,
    output logic packet_ready_b,
    output logic group_check_pin,
    output logic ctl_write,
    output logic [3:0] ctl_addr,
    output logic [7:0] ctl_data
);
    if (UPDATE_CYCLES < 2 || UPDATE_CYCLES > 32'h00ff_ffff)
        $error("UPDATE_CYCLES out of range");

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [20:0] s;
    logic cs_s, rd_s, wr_s, ack_s, bw_s, sp_s, ce_s, cl_s, sdi_s;
    logic [3:0] addr_s;
    logic [7:0] din_s;

    pin_sync #(.WIDTH(21)) u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .pins({~chip_select_b, ~read_b, ~write_b, transfer_acknowledge,
               bus_word, bus_select_pin, chip_enable, serial_clock_in,
               serial_data_in, bus_addr, data_in}),
        .synced(s)
    );
    // strobes pass inverted so the cleared synchroniser reads as idle
    assign {cs_s, rd_s, wr_s} = ~s[20:18];
    assign {ack_s, bw_s, sp_s, ce_s, cl_s, sdi_s} = s[17:12];
    assign addr_s = s[11:8];
    assign din_s = s[7:0];

    // ------------------------------------------------------------
    // packet registers and interrupt
    // ------------------------------------------------------------
    logic [7:0] stat_q;
    logic [7:0] block_number;
    logic [23:0] window_cnt;
    logic check_zero;
    logic [7:0] status_live;
    logic [7:0] stream_mem [0:`STREAM_BYTES-1];
    logic release_int;

    assign status_live = {stat_q[7:2], check_zero, 1'b0};

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stat_q <= 8'h00;
            block_number <= 8'h00;
        end
        else if (clk_en && pkt_load)
        begin
            stat_q[`BIT_SECOND_PASS] <= pkt_second_pass;
            stat_q[`BIT_BLOCK_LOCK] <= pkt_block_locked;
            stat_q[`BIT_FRAME_LOCK] <= pkt_frame_locked;
            stat_q[`BIT_ERROR] <= pkt_error;
            stat_q[`BIT_PARITY] <= pkt_parity;
            stat_q[`BIT_HEAD] <= pkt_head & ~pkt_second_pass;
            // number is passed through even when halted; host must ignore
            block_number <= pkt_number;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (clk_en && pay_we && pay_addr < 6'(`STREAM_BYTES))
            stream_mem[pay_addr] <= pay_wdata;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            window_cnt <= 24'h00_0000;
            packet_ready_b <= 1'b1;
        end
        else if (clk_en)
        begin
            if (pkt_load)
            begin
                window_cnt <= 24'(UPDATE_CYCLES);
                packet_ready_b <= 1'b1;
            end
            else if (window_cnt != 24'h00_0000)
            begin
                window_cnt <= window_cnt - 24'h00_0001;
                if (window_cnt == 24'h00_0001)
                    packet_ready_b <= 1'b0;
            end
            else if (release_int)
                packet_ready_b <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // parallel and dma readout
    // ------------------------------------------------------------
    logic ack_on, par_read, par_read_q, payload_sel, wr_act, wr_act_q;
    logic [5:0] rd_ptr;
    logic pending;

    assign ack_on = acknowledge_active_high ? ack_s : ~ack_s;
    always_comb
    begin
        if (sp_s)
            par_read = 1'b0;
        else if (dma_enable)
            par_read = dma_read_sel ? ack_on : (ack_on & ~rd_s);
        else
            par_read = ~cs_s & ~rd_s;
    end
    assign payload_sel = dma_enable || addr_s == `PAYLOAD_OFS;
    assign wr_act = ~sp_s & ~cs_s & ~wr_s;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            par_read_q <= 1'b0;
            wr_act_q <= 1'b0;
            data_out <= 16'h0000;
            data_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            par_read_q <= par_read;
            wr_act_q <= wr_act;
            data_oe <= par_read;
            if (par_read && !par_read_q)
            begin
                if (payload_sel && rd_ptr < `PAYLOAD_BYTES)
                    data_out <= bw_s ?
                        {stream_mem[rd_ptr], stream_mem[rd_ptr + 6'h01]} :
                        {8'h00, stream_mem[rd_ptr]};
                else if (payload_sel)
                    data_out <= 16'h0000;
                else if (addr_s == `STATUS_OFS)
                    data_out <= {8'h00, status_live};
                else if (addr_s == `BLOCK_OFS)
                    data_out <= {8'h00, block_number};
                else
                    data_out <= 16'h0000;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_ptr <= 6'h00;
            pending <= 1'b0;
        end
        else if (clk_en)
        begin
            if (pkt_load)
            begin
                rd_ptr <= 6'h00;
                pending <= 1'b1;
            end
            else if (!par_read && par_read_q && payload_sel && pending)
            begin
                if (rd_ptr + (bw_s ? 6'h02 : 6'h01) >= `PAYLOAD_BYTES)
                begin
                    rd_ptr <= `PAYLOAD_BYTES;
                    pending <= 1'b0;
                end
                else
                    rd_ptr <= rd_ptr + (bw_s ? 6'h02 : 6'h01);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            transfer_request <= 1'b1;
        else if (clk_en)
            transfer_request <= (dma_enable && !sp_s && pending && !par_read)
                ? request_active_high : ~request_active_high;
    end

    // ------------------------------------------------------------
    // serial bus
    // ------------------------------------------------------------
    serial_mode_e mode;
    logic cl_q, ce_q;
    logic [7:0] serial_code;
    logic [15:0] shift_in;
    logic [8:0] bit_cnt;
    logic [15:0] snapshot;
    logic cl_rise, ce_rise;
    logic out_bit;
    logic [8:0] pay_bit;
    logic [5:0] pay_byte;

    assign cl_rise = cl_s & ~cl_q;
    assign ce_rise = ce_s & ~ce_q;
    assign pay_bit = bit_cnt - 9'h010;
    assign pay_byte = pay_bit[8:3];

    always_comb
    begin
        if (bit_cnt < 9'h010)
            out_bit = snapshot[bit_cnt[3:0]];
        else
            out_bit = stream_mem[pay_byte][3'h7 - pay_bit[2:0]];
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cl_q <= 1'b0;
            ce_q <= 1'b0;
            mode <= MODE_IDLE;
            serial_code <= 8'h00;
            shift_in <= 16'h0000;
            bit_cnt <= 9'h000;
            snapshot <= 16'h0000;
        end
        else if (clk_en)
        begin
            cl_q <= cl_s;
            ce_q <= ce_s;
            if (!ce_s)
            begin
                mode <= MODE_IDLE;
                bit_cnt <= 9'h000;
                if (cl_rise)
                    serial_code <= {sdi_s, serial_code[7:1]};
            end
            else if (ce_rise)
            begin
                snapshot <= {block_number, status_live};
                unique case (serial_code)
                    `CODE_CTRL_IN: mode <= MODE_CTRL_IN;
                    `CODE_DATA_OUT: mode <= MODE_DATA_OUT;
                    `CODE_GROUP_IN: mode <= MODE_GROUP_IN;
                    `CODE_REG_OUT: mode <= MODE_REG_OUT;
                    default: mode <= MODE_IDLE;
                endcase
            end
            else if (cl_rise && mode != MODE_IDLE)
            begin
                shift_in <= {sdi_s, shift_in[15:1]};
                bit_cnt <= bit_cnt + 9'h001;
                if ((mode == MODE_DATA_OUT
                        && bit_cnt == `SERIAL_OUT_BITS - 9'h001)
                    || (mode == MODE_REG_OUT
                        && bit_cnt == `REG_OUT_BITS - 9'h001)
                    || (mode == MODE_CTRL_IN
                        && bit_cnt == 9'(`CTRL_IN_BITS) - 9'h001))
                    mode <= MODE_IDLE;
                if (mode == MODE_GROUP_IN && bit_cnt[2:0] == 3'h7)
                    bit_cnt <= 9'h000;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            serial_out_oe <= 1'b0;
        else if (clk_en)
            serial_out_oe <= (mode == MODE_DATA_OUT || mode == MODE_REG_OUT)
                && !out_bit;
    end
    assign serial_out = 1'b0;

    assign release_int = (par_read && !par_read_q)
        || (ce_rise && serial_code == `CODE_DATA_OUT);

    // ------------------------------------------------------------
    // control writes and group checker feed
    // ------------------------------------------------------------
    logic serial_byte_done, ctrl_done, par_wr_done;
    logic group_valid;
    logic [7:0] group_byte;

    assign serial_byte_done = clk_en && ce_s && !ce_rise && cl_rise
        && mode == MODE_GROUP_IN && bit_cnt[2:0] == 3'h7;
    assign ctrl_done = clk_en && ce_s && !ce_rise && cl_rise
        && mode == MODE_CTRL_IN && bit_cnt == 9'(`CTRL_IN_BITS) - 9'h001;
    assign par_wr_done = !wr_act && wr_act_q;
    assign group_valid = serial_byte_done
        || (par_wr_done && addr_s == `GROUP_OFS);
    assign group_byte = serial_byte_done ? {sdi_s, shift_in[15:9]} : din_s;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl_write <= 1'b0;
            ctl_addr <= 4'h0;
            ctl_data <= 8'h00;
        end
        else if (clk_en)
        begin
            ctl_write <= 1'b0;
            if (ctrl_done)
            begin
                ctl_write <= 1'b1;
                ctl_data <= shift_in[8:1];
                ctl_addr <= shift_in[12:9];
            end
            else if (par_wr_done && addr_s != `GROUP_OFS)
            begin
                ctl_write <= 1'b1;
                ctl_data <= din_s;
                ctl_addr <= addr_s;
            end
        end
    end

    group_check u_check (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .clear(group_check_clear),
        .byte_valid(group_valid && clk_en),
        .byte_in(group_byte),
        .zero(check_zero)
    );
    assign group_check_pin = check_zero;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_depth;
        @(posedge ref_clk) disable iff (!rst_b)
        clk_en && pkt_load |=> stat_q[7] == $past(pkt_second_pass);
    endproperty
    a_depth: assert property (p_depth)
        else $error("depth flag wrong");

    property p_lock;
        @(posedge ref_clk) disable iff (!rst_b)
        clk_en && pkt_load |=>
            stat_q[6:5] == $past({pkt_block_locked, pkt_frame_locked});
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock flags wrong");

    property p_err_par;
        @(posedge ref_clk) disable iff (!rst_b)
        clk_en && pkt_load |=> stat_q[4:3] == $past({pkt_error, pkt_parity});
    endproperty
    a_err_par: assert property (p_err_par)
        else $error("error or parity flag wrong");

    property p_number;
        @(posedge ref_clk) disable iff (!rst_b)
        clk_en && pkt_load |=> block_number == $past(pkt_number);
    endproperty
    a_number: assert property (p_number)
        else $error("block number not loaded");

    property p_window;
        @(posedge ref_clk) disable iff (!rst_b)
        $fell(packet_ready_b) |-> $past(window_cnt) == 24'h00_0001;
    endproperty
    a_window: assert property (p_window)
        else $error("interrupt outside window end");

    property p_status_read;
        @(posedge ref_clk) disable iff (!rst_b)
        clk_en && par_read && !par_read_q && !dma_enable
            && addr_s == `STATUS_OFS
            |=> data_out[7:0] == {$past(stat_q[7:2]), $past(check_zero), 1'b0};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read mismatch");

    property p_pointer;
        @(posedge ref_clk) disable iff (!rst_b)
        rd_ptr <= `PAYLOAD_BYTES;
    endproperty
    a_pointer: assert property (p_pointer)
        else $error("payload pointer past end");

    property p_mode;
        @(posedge ref_clk) disable iff (!rst_b)
        clk_en && ce_rise && serial_code == `CODE_DATA_OUT
            |=> mode == MODE_DATA_OUT;
    endproperty
    a_mode: assert property (p_mode)
        else $error("serial mode not decoded");

    property p_ctl;
        @(posedge ref_clk) disable iff (!rst_b)
        ctrl_done |=> ctl_write && ctl_addr == $past(shift_in[12:9]);
    endproperty
    a_ctl: assert property (p_ctl)
        else $error("serial register write wrong");

    c_serial_out: cover property (@(posedge ref_clk) mode == MODE_DATA_OUT);
    c_dma: cover property (@(posedge ref_clk) dma_enable && par_read);
    c_group: cover property (@(posedge ref_clk) group_valid ##1 check_zero);
endmodule
`default_nettype wire

/* src/readout_map.svh */
/*
 holds offsets, field positions, serial codes and timing counts of the
 host readout side; assumes a 25 MHz core clock.
*/
`ifndef READOUT_MAP_SVH
`define READOUT_MAP_SVH
`define PAYLOAD_OFS 4'h0
`define STATUS_OFS 4'h1
`define BLOCK_OFS 4'h2
`define GROUP_OFS 4'h6
`define BIT_SECOND_PASS 7
`define BIT_BLOCK_LOCK 6
`define BIT_FRAME_LOCK 5
`define BIT_ERROR 4
`define BIT_PARITY 3
`define BIT_HEAD 2
`define BIT_CHECK_OK 1
`define CODE_CTRL_IN 8'hfa
`define CODE_DATA_OUT 8'hfb
`define CODE_GROUP_IN 8'hfc
`define CODE_REG_OUT 8'hfd
`define PAYLOAD_BYTES 6'h16
`define STREAM_BYTES 34
`define SERIAL_OUT_BITS 9'h120
`define REG_OUT_BITS 9'h010
`define CTRL_IN_BITS 5'h10
`define CHECK_POLY 16'h1021
`define UPDATE_WINDOW_NS 1000000
`define CLK_PERIOD_NS 40
`define UPDATE_CYCLES (`UPDATE_WINDOW_NS / `CLK_PERIOD_NS)
`endif

/* src/readout_pkg.sv */
/*
 holds the types of the host readout side; assumes readout_map.svh.
*/
package readout_pkg;
    typedef enum logic [2:0] {
        MODE_IDLE,
        MODE_CTRL_IN,
        MODE_DATA_OUT,
        MODE_GROUP_IN,
        MODE_REG_OUT
    } serial_mode_e;
endpackage

/* src/pin_sync.sv */
/*
 two-flop synchroniser for a group of pins; assumes pins are asynchronous
 to ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] first;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            first <= '0;
            synced <= '0;
        end
        else if (clk_en)
        begin
            first <= pins;
            synced <= first;
        end
    end
endmodule
`default_nettype wire

/* src/group_check.sv */
/*
 bytewise 16-bit group checker, msb first; assumes one byte per strobe.
*/
`timescale 1ns/100ps
`default_nettype none
`include "readout_map.svh"
module group_check (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic byte_valid,
    input wire logic [7:0] byte_in,
    output logic zero
);
    logic [15:0] remainder;
    logic [15:0] next_remainder;

    // ------------------------------------------------------------
    // division register
    // ------------------------------------------------------------
    always_comb
    begin
        next_remainder = remainder;
        for (int i = 7; i >= 0; i--)
        begin
            if (next_remainder[15] ^ byte_in[i])
                next_remainder = {next_remainder[14:0], 1'b0} ^ `CHECK_POLY;
            else
                next_remainder = {next_remainder[14:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            remainder <= 16'h0000;
        else if (clk_en)
        begin
            if (clear)
                remainder <= 16'h0000;
            else if (byte_valid)
                remainder <= next_remainder;
        end
    end

    assign zero = (remainder == 16'h0000);

    property p_clear_holds;
        @(posedge ref_clk) disable iff (!rst_b)
        clear && clk_en |=> zero;
    endproperty
    a_clear_holds: assert property (p_clear_holds)
        else $error("checker not zero after clear");
endmodule
`default_nettype wire

/* sim/host_serial.sv */
/*
 host model on the serial bus: sends a code, then clocks data in or out.
 assumes a 320 ns bit period with clock and enable idle low.
*/
`timescale 1ns/100ps
`default_nettype none
module host_serial (
    output logic serial_clock_in,
    output logic chip_enable,
    output logic serial_data_in,
    input wire logic serial_out_oe
);
    initial {serial_clock_in, chip_enable, serial_data_in} = 3'b000;
    // --------------------------------
    // one framed transfer
    // --------------------------------
    task automatic xfer(input logic [7:0] code, input int n,
        input logic [31:0] wd, output logic [31:0] rd);
        rd = '0;
        for (int i = 0; i < 8 + n; i++)
        begin
            if (i == 8)
                chip_enable = 1'b1;
            serial_data_in = (i < 8) ? code[i] : wd[i-8];
            #160;
            if (i >= 8)
                rd[i-8] = ~serial_out_oe;
            serial_clock_in = 1'b1;
            #160 serial_clock_in = 1'b0;
        end
        #160 chip_enable = 1'b0;
        serial_data_in = ~serial_data_in;
    endtask
endmodule
`default_nettype wire

/* sim/decoder_host_readout_and_l4_check_tb_top.sv */
/*
 self-checking bench for the host readout side.
 assumes host_serial drives the serial pins; bench drives the rest.
*/
`timescale 1ns/100ps
`default_nettype none
module decoder_host_readout_and_l4_check_tb_top;
    localparam int UPD = 20;
    logic ref_clk = 0, rst_b = 0, clk_en = 1, pkt_load = 0, pay_we = 0;
    logic pkt_second_pass = 0, pkt_block_locked = 0, pkt_frame_locked = 0;
    logic pkt_error = 0, pkt_parity = 0, pkt_head = 0, bus_word = 0;
    logic [7:0] pkt_number = 0, pay_wdata = 0, data_in = 0, f, b;
    logic [5:0] pay_addr = 0;
    logic second_pass_halt = 0, group_check_clear = 0, dma_enable = 0;
    logic dma_read_sel = 0, request_active_high = 0, bus_select_pin = 0;
    logic acknowledge_active_high = 0, transfer_acknowledge = 1;
    logic chip_select_b = 1, read_b = 1, write_b = 1;
    logic [3:0] bus_addr = 0, ctl_addr;
    logic [15:0] data_out, crc, st;
    logic [7:0] ctl_data, pay [0:23];
    logic [11:0] seen_ctl = '0;
    logic [31:0] rd;
    logic data_oe, transfer_request, serial_out, serial_out_oe;
    logic packet_ready_b, group_check_pin, ctl_write;
    wire logic serial_clock_in, chip_enable, serial_data_in;
    int n_mismatch = 0, tests_run = 0, seed = 9, cycles = 0;

    always #20 ref_clk = ~ref_clk;
    decoder_host_readout_and_l4_check #(.UPDATE_CYCLES(UPD))
        u_decoder_host_readout_and_l4_check (.*);
    host_serial u_host_serial (.*);
    always @(posedge ref_clk)
        if (ctl_write)
            seen_ctl <= {ctl_addr, ctl_data};
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end
    // --------------------------------
    // helpers
    // --------------------------------
    task automatic report_and_stop();
        if (n_mismatch == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] e, g);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    function automatic logic [15:0] crc_byte(input logic [15:0] c,
        input logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction
    function automatic logic [7:0] rev8(input logic [7:0] d);
        return {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]};
    endfunction
    task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
        @(negedge ref_clk);
        {bus_addr, chip_select_b, read_b} = {a, 2'b00};
        repeat (4) @(negedge ref_clk);
        d = data_out;
        check("read enable", 16'h0001, {15'h0, data_oe});
        {chip_select_b, read_b} = 2'b11;
        repeat (3) @(negedge ref_clk);
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        {bus_addr, data_in, chip_select_b, write_b} = {a, d, 2'b00};
        repeat (3) @(negedge ref_clk);
        {chip_select_b, write_b} = 2'b11;
        repeat (4) @(negedge ref_clk);
    endtask
    // --------------------------------
    // main sequence
    // --------------------------------
    initial
    begin
        for (int i = 0; i < 24; i++)
            pay[i] = 8'h00;
        repeat (3) @(negedge ref_clk);
        rst_b = 1'b1;
        check("request idle", 16'h0001, {15'h0000, transfer_request});
        check("ready idle", 16'h0001, {15'h0000, packet_ready_b});
        check("check pin reset", 16'h0001, {15'h0000, group_check_pin});
        bus_wr(4'h4, 8'h80);
        check("ctl write", 16'h0480, {4'h0, seen_ctl});
        group_check_clear = 1'b1;
        repeat (2) @(negedge ref_clk);
        group_check_clear = 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            crc = 16'h0000;
            for (int j = 0; j <= k * 5; j++)
            begin
                b = $random(seed);
                bus_wr(4'h6, b);
                crc = crc_byte(crc, b);
            end
            bus_wr(4'h6, crc[15:8]);
            bus_wr(4'h6, crc[7:0]);
            check("group ok", 16'h0001, {15'h0000, group_check_pin});
        end
        bus_wr(4'h6, 8'h5a);
        check("group bad", 16'h0000, {15'h0000, group_check_pin});
        for (int p = 0; p < 2; p++)
        begin
            if (p == 1)
            begin
                group_check_clear = 1'b1;
                @(negedge ref_clk);
                check("clear held", 16'h0001, {15'h0000, group_check_pin});
                group_check_clear = 1'b0;
            end
            for (int i = 0; i < 22; i++)
            begin
                pay[i] = $random(seed);
                {pay_addr, pay_wdata, pay_we} = {6'(i), pay[i], 1'b1};
                @(negedge ref_clk);
            end
            pay_we = 1'b0;
            f = $random(seed);
            pkt_number = $random(seed) & 8'h7f;
            {pkt_second_pass, pkt_block_locked, pkt_frame_locked} = f[7:5];
            {pkt_error, pkt_parity, pkt_head, pkt_load} = {f[4:2], 1'b1};
            @(negedge ref_clk);
            pkt_load = 1'b0;
            repeat (UPD - 2) @(negedge ref_clk);
            check("irq early", 16'h0001, {15'h0000, packet_ready_b});
            repeat (6) @(negedge ref_clk);
            check("irq", 16'h0000, {15'h0000, packet_ready_b});
            st = {8'h00, f[7:3], f[2] & ~f[7], p[0], 1'b0};
            bus_rd(4'h1, rd[15:0]);
            check("status", st, {8'h00, rd[7:0]});
            check("irq released", 16'h0001, {15'h0, packet_ready_b});
            bus_rd(4'h2, rd[15:0]);
            check("number", {8'h00, pkt_number}, {8'h00, rd[7:0]});
            bus_word = p[0];
            dma_enable = p[0];
            transfer_acknowledge = ~p[0];
            for (int i = 0; i < 24; i += 1 + p)
            begin
                bus_rd(4'h0, rd[15:0]);
                if (p == 1)
                    check("word", {pay[i], pay[i+1]}, rd[15:0]);
                else
                    check("byte", {8'h00, pay[i]}, {8'h00, rd[7:0]});
                if (p == 1 && i == 0)
                    check("req on", 16'h0000, {15'h0, transfer_request});
            end
            {bus_word, dma_enable, transfer_acknowledge} = 3'b001;
            check("req off", 16'h0001, {15'h0, transfer_request});
        end
        bus_select_pin = 1'b1;
        repeat (4) @(negedge ref_clk);
        u_host_serial.xfer(8'hfd, 16, 32'h0, rd);
        check("reg out", {pkt_number, st[7:0]}, rd[15:0]);
        check("serial low", 16'h0000, {15'h0, serial_out});
        u_host_serial.xfer(8'hfb, 32, 32'h0, rd);
        check("data head", {pkt_number, st[7:0]}, rd[15:0]);
        check("data body", {rev8(pay[1]), rev8(pay[0])}, rd[31:16]);
        u_host_serial.xfer(8'hfa, 16, 32'h9_3a5, rd);
        check("serial ctl", 16'h03a5, {4'h0, seen_ctl});
        b = $random(seed) | 8'h01;
        crc = crc_byte(16'h0000, b);
        u_host_serial.xfer(8'hfc, 8, {24'h0, b}, rd);
        check("serial byte", 16'h0000, {15'h0, group_check_pin});
        u_host_serial.xfer(8'hfc, 16, {16'h0, crc[7:0], crc[15:8]}, rd);
        check("serial group", 16'h0001, {15'h0, group_check_pin});
        report_and_stop();
    end
endmodule
`default_nettype wire
